// *** hw/mbox_overlay.sv ***
// module: moving box overlay for two output paths with avalon-mm control
`timescale 1ns/1ps
`default_nettype none
module mbox_overlay (
  input wire logic sys_clk, // pixel and bus clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic [mbox_pkg::ADDR_W-1:0] avs_address, // word address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // write byte lanes
  output logic [31:0] avs_readdata, // read data, registered
  output logic avs_waitrequest, // high stalls the master
  input wire logic [mbox_pkg::NPATH-1:0][mbox_pkg::DW-1:0] vid_in_data, // pixels in
  input wire logic [mbox_pkg::NPATH-1:0] vid_in_valid, // active pixel
  input wire logic [mbox_pkg::NPATH-1:0] vid_in_sof, // first pixel of frame
  input wire logic [mbox_pkg::NPATH-1:0] vid_in_eol, // last pixel of line
  input wire logic [mbox_pkg::NPATH-1:0] input_signal_lost, // path input is lost
  input wire logic [mbox_pkg::NPATH-1:0] raster_generated, // output makes its own raster
  output logic [mbox_pkg::NPATH-1:0][mbox_pkg::DW-1:0] vid_out_data, // pixels out
  output logic [mbox_pkg::NPATH-1:0] vid_out_valid, // delayed valid
  output logic [mbox_pkg::NPATH-1:0] vid_out_sof, // delayed sof
  output logic [mbox_pkg::NPATH-1:0] vid_out_eol // delayed eol
);
  localparam int CW = mbox_pkg::CW;
  localparam mbox_pkg::mbox_state_t ST_RST = '{
    p: {mbox_pkg::NPATH{mbox_pkg::PATH_RST}},
    bus: mbox_pkg::BUS_IDLE,
    rdata: 32'h0000_0000
  };

  mbox_pkg::mbox_state_t s_q, s_d;
  logic [mbox_pkg::NPATH-1:0] in_box;
  logic bus_req;
  logic wr_take;

  function automatic logic [CW-1:0] pct_of(input logic [mbox_pkg::PCT_W-1:0] pct,
                                           input logic [CW-1:0] full);
    logic [29:0] t;
    t = 30'(pct) * 30'(full) * 30'(mbox_pkg::DIV100_MUL);
    return t[mbox_pkg::DIV100_SHIFT +: CW];
  endfunction

  // returns {dir, pos}; a position beyond the limit after a format shrink is pulled back
  function automatic logic [CW:0] bounce(input logic [CW-1:0] pos, input logic dir,
                                         input logic [7:0] spd, input logic [CW-1:0] lim);
    logic [CW:0] sx;
    logic [CW:0] sum;
    logic [CW:0] r;
    sx = (CW+1)'(spd);
    sum = (CW+1)'(pos) + sx;
    if (pos > lim) begin
      r = {1'b1, lim};
    end else if (!dir) begin
      r = (sum >= (CW+1)'(lim)) ? {1'b1, lim} : {1'b0, sum[CW-1:0]};
    end else begin
      r = ((CW+1)'(pos) <= sx) ? {1'b0, {CW{1'b0}}} : {1'b1, pos - sx[CW-1:0]};
    end
    return r;
  endfunction

  function automatic logic [31:0] reg_word(input mbox_pkg::mbox_path_t p,
                                           input logic [2:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      mbox_pkg::REG_CTRL: begin
        w[mbox_pkg::CTRL_EN_BIT] = p.en;
        w[mbox_pkg::CTRL_LOSS_BIT] = p.on_loss;
      end
      mbox_pkg::REG_SIZE: begin
        w[mbox_pkg::SIZE_W_LSB +: mbox_pkg::PCT_W] = p.w_pct;
        w[mbox_pkg::SIZE_H_LSB +: mbox_pkg::PCT_W] = p.h_pct;
      end
      mbox_pkg::REG_ATTR: begin
        w[mbox_pkg::ATTR_OPAC_LSB +: mbox_pkg::OPAC_W] = p.opac;
        w[mbox_pkg::ATTR_COL_LSB +: mbox_pkg::SEL_W] = p.color;
      end
      mbox_pkg::REG_SPEED: begin
        w[mbox_pkg::SPEED_H_LSB +: mbox_pkg::SEL_W] = p.hspd;
        w[mbox_pkg::SPEED_V_LSB +: mbox_pkg::SEL_W] = p.vspd;
      end
      mbox_pkg::REG_RASTER: begin
        w[0 +: CW] = p.meas_w;
        w[mbox_pkg::HI_LSB +: CW] = p.meas_h;
      end
      mbox_pkg::REG_POS: begin
        w[0 +: CW] = p.pos_x;
        w[mbox_pkg::HI_LSB +: CW] = p.pos_y;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  assign bus_req = avs_read | avs_write;
  // one wait cycle per access keeps read data a clean flip-flop output
  assign avs_waitrequest = bus_req & (s_q.bus != mbox_pkg::BUS_ACK);
  assign wr_take = avs_write & (s_q.bus == mbox_pkg::BUS_ACK);
  assign avs_readdata = s_q.rdata;

  always_comb begin
    logic [31:0] bm;
    logic [31:0] nw;
    logic [CW-1:0] x_now;
    logic [CW-1:0] y_now;
    logic [CW-1:0] lim;
    logic [CW:0] stp;
    s_d = s_q;
    in_box = '0;
    bm = 32'h0000_0000;
    nw = 32'h0000_0000;
    x_now = '0;
    y_now = '0;
    lim = '0;
    stp = '0;
    for (int b = 0; b < 4; b++) begin
      bm[8*b +: 8] = {8{avs_byteenable[b]}};
    end
    unique case (s_q.bus)
      mbox_pkg::BUS_IDLE: begin
        if (bus_req) begin
          s_d.bus = mbox_pkg::BUS_ACK;
          if (avs_read) begin
            s_d.rdata = reg_word(s_q.p[avs_address[mbox_pkg::PATH_BIT]], avs_address[2:0]);
          end
        end
      end
      mbox_pkg::BUS_ACK: begin
        s_d.bus = mbox_pkg::BUS_IDLE;
      end
      default: begin
        s_d.bus = mbox_pkg::BUS_IDLE;
      end
    endcase
    for (int i = 0; i < mbox_pkg::NPATH; i++) begin
      if (wr_take && i == int'(avs_address[mbox_pkg::PATH_BIT])) begin
        nw = (reg_word(s_q.p[i], avs_address[2:0]) & ~bm) | (avs_writedata & bm);
        case (avs_address[2:0])
          mbox_pkg::REG_CTRL: begin
            s_d.p[i].en = nw[mbox_pkg::CTRL_EN_BIT];
            s_d.p[i].on_loss = nw[mbox_pkg::CTRL_LOSS_BIT];
          end
          mbox_pkg::REG_SIZE: begin
            s_d.p[i].w_pct = (nw[mbox_pkg::SIZE_W_LSB +: mbox_pkg::PCT_W] > mbox_pkg::PCT_MAX)
                ? mbox_pkg::PCT_MAX : nw[mbox_pkg::SIZE_W_LSB +: mbox_pkg::PCT_W];
            s_d.p[i].h_pct = (nw[mbox_pkg::SIZE_H_LSB +: mbox_pkg::PCT_W] > mbox_pkg::PCT_MAX)
                ? mbox_pkg::PCT_MAX : nw[mbox_pkg::SIZE_H_LSB +: mbox_pkg::PCT_W];
          end
          mbox_pkg::REG_ATTR: begin
            s_d.p[i].opac = (nw[mbox_pkg::ATTR_OPAC_LSB +: mbox_pkg::OPAC_W] > mbox_pkg::OPAC_MAX)
                ? mbox_pkg::OPAC_MAX : nw[mbox_pkg::ATTR_OPAC_LSB +: mbox_pkg::OPAC_W];
            s_d.p[i].color = mbox_pkg::mbox_color_t'(
                nw[mbox_pkg::ATTR_COL_LSB +: mbox_pkg::SEL_W]);
          end
          mbox_pkg::REG_SPEED: begin
            s_d.p[i].hspd = nw[mbox_pkg::SPEED_H_LSB +: mbox_pkg::SEL_W];
            s_d.p[i].vspd = nw[mbox_pkg::SPEED_V_LSB +: mbox_pkg::SEL_W];
          end
          default: begin
          end
        endcase
      end
      // a lost input only shows the box on a generated raster, whatever the mode
      s_d.p[i].draw = s_q.p[i].en &
          (input_signal_lost[i] ? raster_generated[i] : ~s_q.p[i].on_loss);
      x_now = vid_in_sof[i] ? '0 : s_q.p[i].cnt_x;
      y_now = vid_in_sof[i] ? '0 : s_q.p[i].cnt_y;
      // the first pixel of a frame still sees last frame's position
      in_box[i] = s_q.p[i].draw && vid_in_valid[i] &&
          x_now >= s_q.p[i].pos_x && y_now >= s_q.p[i].pos_y &&
          (CW+1)'(x_now) < (CW+1)'(s_q.p[i].pos_x) + (CW+1)'(s_q.p[i].box_w) &&
          (CW+1)'(y_now) < (CW+1)'(s_q.p[i].pos_y) + (CW+1)'(s_q.p[i].box_h);
      if (vid_in_valid[i]) begin
        if (vid_in_sof[i]) begin
          s_d.p[i].meas_w = s_q.p[i].line_w;
          s_d.p[i].meas_h = s_q.p[i].cnt_y;
          s_d.p[i].box_w = pct_of(s_q.p[i].w_pct, s_q.p[i].line_w);
          s_d.p[i].box_h = pct_of(s_q.p[i].h_pct, s_q.p[i].cnt_y);
          lim = s_q.p[i].line_w - s_d.p[i].box_w;
          stp = bounce(s_q.p[i].pos_x, s_q.p[i].dir_x, mbox_pkg::SPEED_TAB[s_q.p[i].hspd],
                       lim);
          s_d.p[i].dir_x = stp[CW];
          s_d.p[i].pos_x = stp[CW-1:0];
          lim = s_q.p[i].cnt_y - s_d.p[i].box_h;
          stp = bounce(s_q.p[i].pos_y, s_q.p[i].dir_y, mbox_pkg::SPEED_TAB[s_q.p[i].vspd],
                       lim);
          s_d.p[i].dir_y = stp[CW];
          s_d.p[i].pos_y = stp[CW-1:0];
        end
        if (vid_in_eol[i]) begin
          s_d.p[i].line_w = x_now + CW'(1);
          s_d.p[i].cnt_x = '0;
          s_d.p[i].cnt_y = y_now + CW'(1);
        end else begin
          s_d.p[i].cnt_x = x_now + CW'(1);
          s_d.p[i].cnt_y = y_now;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_bus_answer: assert property (bus_req |-> ##[0:1] !avs_waitrequest)
    else $error("bus access not answered within one cycle");

  for (genvar g = 0; g < mbox_pkg::NPATH; g++) begin : g_path
    mbox_blend u_blend (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .in_data(vid_in_data[g]),
      .in_valid(vid_in_valid[g]),
      .in_sof(vid_in_sof[g]),
      .in_eol(vid_in_eol[g]),
      .in_box(in_box[g]),
      .color(s_q.p[g].color),
      .opacity(s_q.p[g].opac),
      .out_data(vid_out_data[g]),
      .out_valid(vid_out_valid[g]),
      .out_sof(vid_out_sof[g]),
      .out_eol(vid_out_eol[g])
    );

    a_path_isolated: assert property (
      avs_write && !avs_waitrequest && avs_address[mbox_pkg::PATH_BIT] != 1'(g)
      |=> $stable(s_q.p[g].w_pct) && $stable(s_q.p[g].opac) && $stable(s_q.p[g].en))
      else $error("write to one path changed the other");
    a_mode_select: assert property (
      s_q.p[g].en && !input_signal_lost[g] |=> s_q.p[g].draw == !$past(s_q.p[g].on_loss))
      else $error("box drawing does not follow mode");
    a_loss_no_raster: assert property (
      input_signal_lost[g] && !raster_generated[g] |=> !s_q.p[g].draw)
      else $error("box drawn on loss without raster");
    a_width_limit: assert property (
      24'(s_q.p[g].box_w) * 24'(mbox_pkg::PCT_FULL) <=
      24'(s_q.p[g].meas_w) * 24'(mbox_pkg::PCT_MAX) + 24'(mbox_pkg::PCT_FULL))
      else $error("box wider than allowed");
    a_height_limit: assert property (
      24'(s_q.p[g].box_h) * 24'(mbox_pkg::PCT_FULL) <=
      24'(s_q.p[g].meas_h) * 24'(mbox_pkg::PCT_MAX) + 24'(mbox_pkg::PCT_FULL))
      else $error("box taller than allowed");
    a_hstep: assert property (
      vid_in_valid[g] && vid_in_sof[g] && !s_q.p[g].dir_x
      |=> s_q.p[g].dir_x ||
          s_q.p[g].pos_x == $past(s_q.p[g].pos_x) + CW'(mbox_pkg::SPEED_TAB[$past(s_q.p[g].hspd)]))
      else $error("horizontal step wrong");
    a_vstep: assert property (
      vid_in_valid[g] && vid_in_sof[g] && !s_q.p[g].dir_y
      |=> s_q.p[g].dir_y ||
          s_q.p[g].pos_y == $past(s_q.p[g].pos_y) + CW'(mbox_pkg::SPEED_TAB[$past(s_q.p[g].vspd)]))
      else $error("vertical step wrong");
    a_box_inside: assert property (
      (CW+1)'(s_q.p[g].pos_x) + (CW+1)'(s_q.p[g].box_w) <= (CW+1)'(s_q.p[g].meas_w) &&
      (CW+1)'(s_q.p[g].pos_y) + (CW+1)'(s_q.p[g].box_h) <= (CW+1)'(s_q.p[g].meas_h))
      else $error("box left the raster");
    a_hold_frame: assert property (
      !(vid_in_valid[g] && vid_in_sof[g]) |=> $stable(s_q.p[g].pos_x) && $stable(s_q.p[g].pos_y))
      else $error("box moved inside a frame");
    a_recompute: assert property (
      vid_in_valid[g] && vid_in_sof[g]
      |=> s_q.p[g].meas_w == $past(s_q.p[g].line_w) &&
          s_q.p[g].box_w == pct_of($past(s_q.p[g].w_pct), s_q.p[g].meas_w))
      else $error("box size not recomputed at frame start");
    a_width_clamp: assert property (s_q.p[g].w_pct <= mbox_pkg::PCT_MAX)
      else $error("width percentage above range");
    a_height_clamp: assert property (s_q.p[g].h_pct <= mbox_pkg::PCT_MAX)
      else $error("height percentage above range");
    a_opac_clamp: assert property (s_q.p[g].opac <= mbox_pkg::OPAC_MAX)
      else $error("opacity above range");
    a_disabled_off: assert property (!s_q.p[g].en |=> !s_q.p[g].draw)
      else $error("box drawn while disabled");
    a_hspeed_write: assert property (
      avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address == {1'(g), mbox_pkg::REG_SPEED}
      |=> s_q.p[g].hspd == $past(avs_writedata[mbox_pkg::SPEED_H_LSB +: mbox_pkg::SEL_W]))
      else $error("horizontal speed write lost");
    a_vspeed_write: assert property (
      avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address == {1'(g), mbox_pkg::REG_SPEED}
      |=> s_q.p[g].vspd == $past(avs_writedata[mbox_pkg::SPEED_V_LSB +: mbox_pkg::SEL_W]))
      else $error("vertical speed write lost");
  end
endmodule
`default_nettype wire

// *** hw/mbox_pkg.sv ***
// package: constants, register map and state types of the moving box overlay
package mbox_pkg;
  localparam int NPATH = 2;
  localparam int CW = 13;
  localparam int PW = 10;
  localparam int DW = 3 * PW;
  localparam int PCT_W = 6;
  localparam int OPAC_W = 7;
  localparam int SEL_W = 3;
  localparam int ADDR_W = 4;
  localparam int PATH_BIT = 3;
  localparam logic [PCT_W-1:0] PCT_MAX = 6'h28;
  localparam logic [OPAC_W-1:0] PCT_FULL = 7'h64;
  localparam logic [OPAC_W-1:0] OPAC_MAX = PCT_FULL;
  // x/100 is done as x*1311>>17 to avoid a divider
  localparam logic [10:0] DIV100_MUL = 11'h51f;
  localparam int DIV100_SHIFT = 17;
  // opacity 0..100 maps to alpha 0..128
  localparam int ALPHA_SHIFT_IN = 10;
  localparam int ALPHA_W = 8;
  localparam logic [ALPHA_W-1:0] ALPHA_ONE = 8'h80;
  localparam int ALPHA_SHIFT = 7;
  // word index within a path; address bit PATH_BIT picks the path
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_SIZE = 3'h1;
  localparam logic [2:0] REG_ATTR = 3'h2;
  localparam logic [2:0] REG_SPEED = 3'h3;
  localparam logic [2:0] REG_RASTER = 3'h4;
  localparam logic [2:0] REG_POS = 3'h5;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LOSS_BIT = 1;
  localparam int SIZE_W_LSB = 0;
  localparam int SIZE_H_LSB = 8;
  localparam int ATTR_OPAC_LSB = 0;
  localparam int ATTR_COL_LSB = 8;
  localparam int SPEED_H_LSB = 0;
  localparam int SPEED_V_LSB = 4;
  localparam int HI_LSB = 16;
  localparam logic [PCT_W-1:0] RST_W_PCT = 6'h0a;
  localparam logic [PCT_W-1:0] RST_H_PCT = 6'h0a;
  localparam logic [OPAC_W-1:0] RST_OPAC = 7'h64;
  localparam logic [SEL_W-1:0] RST_SPD = 3'h2;
  typedef enum logic [SEL_W-1:0] {
    COL_WHITE = 3'h0, COL_YELLOW = 3'h1, COL_BLACK = 3'h2, COL_RED = 3'h3,
    COL_GREEN = 3'h4, COL_BLUE = 3'h5, COL_CYAN = 3'h6, COL_MAGENTA = 3'h7
  } mbox_color_t;
  // {y, cb, cr} 10-bit, indexed by mbox_color_t
  localparam logic [7:0][DW-1:0] COLOR_TAB = {
    {10'h139, 10'h359, 10'h397}, {10'h2f2, 10'h267, 10'h040},
    {10'h07f, 10'h3c0, 10'h1d7}, {10'h2b3, 10'h0a7, 10'h069},
    {10'h0fa, 10'h199, 10'h3c0}, {10'h040, 10'h200, 10'h200},
    {10'h36d, 10'h040, 10'h229}, {10'h3ac, 10'h200, 10'h200}
  };
  // step per frame in pixels or lines for each speed choice
  localparam logic [7:0][7:0] SPEED_TAB = {
    8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00
  };
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} mbox_bus_t;
  typedef struct packed {
    logic en;
    logic on_loss;
    logic [PCT_W-1:0] w_pct;
    logic [PCT_W-1:0] h_pct;
    logic [OPAC_W-1:0] opac;
    mbox_color_t color;
    logic [SEL_W-1:0] hspd;
    logic [SEL_W-1:0] vspd;
    logic [CW-1:0] cnt_x;
    logic [CW-1:0] cnt_y;
    logic [CW-1:0] line_w;
    logic [CW-1:0] meas_w;
    logic [CW-1:0] meas_h;
    logic [CW-1:0] box_w;
    logic [CW-1:0] box_h;
    logic [CW-1:0] pos_x;
    logic [CW-1:0] pos_y;
    logic dir_x;
    logic dir_y;
    logic draw;
  } mbox_path_t;
  localparam mbox_path_t PATH_RST = '{
    w_pct: RST_W_PCT, h_pct: RST_H_PCT, opac: RST_OPAC, color: COL_WHITE,
    hspd: RST_SPD, vspd: RST_SPD, default: '0
  };
  typedef struct packed {
    mbox_path_t [NPATH-1:0] p;
    mbox_bus_t bus;
    logic [31:0] rdata;
  } mbox_state_t;
  typedef struct packed {
    logic [DW-1:0] data;
    logic valid;
    logic sof;
    logic eol;
  } mbox_pix_t;
endpackage

// *** hw/mbox_blend.sv ***
// module: per-pixel mix of the box colour over the picture, one pipeline stage
`timescale 1ns/1ps
`default_nettype none
module mbox_blend (
  input wire logic sys_clk, // pixel clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic [mbox_pkg::DW-1:0] in_data, // {y, cb, cr} in
  input wire logic in_valid, // active pixel
  input wire logic in_sof, // first pixel of frame
  input wire logic in_eol, // last pixel of line
  input wire logic in_box, // pixel lies inside the drawn box
  input wire mbox_pkg::mbox_color_t color, // box colour choice
  input wire logic [mbox_pkg::OPAC_W-1:0] opacity, // 0..100 percent
  output logic [mbox_pkg::DW-1:0] out_data, // mixed pixel
  output logic out_valid, // delayed in_valid
  output logic out_sof, // delayed in_sof
  output logic out_eol // delayed in_eol
);
  mbox_pkg::mbox_pix_t s_q, s_d;
  logic [mbox_pkg::ALPHA_W-1:0] alpha;
  logic [mbox_pkg::DW-1:0] col;

  always_comb begin
    logic [17:0] at;
    logic [18:0] mix;
    at = 18'(opacity) * 18'(mbox_pkg::DIV100_MUL);
    mix = '0;
    alpha = at[mbox_pkg::ALPHA_SHIFT_IN +: mbox_pkg::ALPHA_W];
    col = mbox_pkg::COLOR_TAB[color];
    s_d.valid = in_valid;
    s_d.sof = in_sof;
    s_d.eol = in_eol;
    s_d.data = in_data;
    if (in_box) begin
      for (int c = 0; c < 3; c++) begin
        mix = 19'(in_data[c*mbox_pkg::PW +: mbox_pkg::PW]) * 19'(mbox_pkg::ALPHA_ONE - alpha)
            + 19'(col[c*mbox_pkg::PW +: mbox_pkg::PW]) * 19'(alpha);
        s_d.data[c*mbox_pkg::PW +: mbox_pkg::PW] = mix[mbox_pkg::ALPHA_SHIFT +: mbox_pkg::PW];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_data = s_q.data;
  assign out_valid = s_q.valid;
  assign out_sof = s_q.sof;
  assign out_eol = s_q.eol;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_full_opacity: assert property (
    in_valid && in_box && opacity == mbox_pkg::OPAC_MAX
    |=> out_data == mbox_pkg::COLOR_TAB[$past(color)]) else $error("box not opaque at full");
  a_zero_opacity: assert property (
    in_valid && in_box && opacity == '0 |=> out_data == $past(in_data))
    else $error("box visible at zero opacity");
  a_outside_pass: assert property (
    in_valid && !in_box |=> out_data == $past(in_data) && out_valid)
    else $error("pixel outside box altered");
endmodule
`default_nettype wire

// *** dv/mbox_sink.sv ***
// downstream raster receiver model: counts the frames and lines it is handed
`timescale 1ns/1ps
`default_nettype none
module mbox_sink (
  input wire logic sys_clk, // pixel clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic valid, // active pixel
  input wire logic sof, // first pixel of frame
  input wire logic eol, // last pixel of line
  output var int frames, // frames received
  output var int lines // lines received
);
  always @(posedge sys_clk) begin
    if (!rstn) begin
      frames <= 0;
      lines <= 0;
    end else if (valid === 1'b1) begin
      frames <= frames + int'(sof === 1'b1);
      lines <= lines + int'(eol === 1'b1);
    end
  end
endmodule
`default_nettype wire

// *** dv/mbox_overlay_tb.sv ***
// self-checking bench for the moving box overlay: registers, mixing, modes, motion
`timescale 1ns/1ps
`default_nettype none
module mbox_overlay_tb;
  localparam int NP = mbox_pkg::NPATH;
  localparam logic [31:0] RST_TAB [8] = '{32'h0000_0000, 32'h0000_0a0a, 32'h0000_0064,
    32'h0000_0022, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  logic sys_clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [NP-1:0][mbox_pkg::DW-1:0] vin_d, vout_d;
  logic [NP-1:0] vin_v, vin_s, vin_e, lost, rgen, vout_v, vout_s, vout_e;
  int mismatches, cmp_count, frames_sent, pw, ph;
  int fr [NP], ln [NP], en [NP], onl [NP], wp [NP], hp [NP], op [NP], col [NP];
  int lbw [NP], lbh [NP];
  logic [mbox_pkg::DW-1:0] expq [NP][$];

  mbox_overlay i_mbox_overlay (
    .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .vid_in_data(vin_d), .vid_in_valid(vin_v), .vid_in_sof(vin_s), .vid_in_eol(vin_e),
    .input_signal_lost(lost), .raster_generated(rgen), .vid_out_data(vout_d),
    .vid_out_valid(vout_v), .vid_out_sof(vout_s), .vid_out_eol(vout_e)
  );
  for (genvar g = 0; g < NP; g++) begin : g_sink
    mbox_sink i_mbox_sink (.sys_clk(sys_clk), .rstn(rstn), .valid(vout_v[g]),
      .sof(vout_s[g]), .eol(vout_e[g]), .frames(fr[g]), .lines(ln[g]));
  end

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pix(input logic [29:0] got, input logic [29:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t pixel %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; the request is held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100) mismatches++;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'h0, q);
    check_reg(q, e);
  endtask

  task automatic cfg(input int p, input int e, input int ol, input int w, input int h,
                     input int o, input int c, input int hs, input int vs);
    en[p] = e;
    onl[p] = ol;
    wp[p] = w;
    hp[p] = h;
    op[p] = o;
    col[p] = c;
    wr(4'(p * 8), 32'(ol * 2 + e));
    wr(4'(p * 8 + 1), 32'(h * 256 + w));
    wr(4'(p * 8 + 2), 32'(c * 256 + o));
    wr(4'(p * 8 + 3), 32'(vs * 16 + hs));
  endtask

  // box sits at the origin while both speeds are zero; size comes from the previous frame
  function automatic logic [29:0] expect_pix(input int p, input int x, input int y,
                                             input logic [29:0] pix);
    int bw, bh, a;
    logic [29:0] cv, r;
    bw = (wp[p] * pw * 1311) >> 17;
    bh = (hp[p] * ph * 1311) >> 17;
    // the first pixel of a frame still uses the size set at the previous frame start
    if (x == 0 && y == 0) begin
      {bw, lbw[p]} = {lbw[p], bw};
      {bh, lbh[p]} = {lbh[p], bh};
    end
    a = (op[p] * 1311) >> 10;
    cv = mbox_pkg::COLOR_TAB[col[p]];
    r = pix;
    if (en[p] != 0 && (lost[p] ? rgen[p] : (onl[p] == 0)) && x < bw && y < bh)
      for (int k = 0; k < 3; k++)
        r[k*10 +: 10] = 10'((int'(pix[k*10 +: 10]) * (128 - a) + int'(cv[k*10 +: 10]) * a) >> 7);
    return r;
  endfunction

  task automatic frame(input int w, input int h);
    logic [29:0] d;
    for (int y = 0; y < h; y++) begin
      for (int x = 0; x < w; x++) begin
        @(posedge sys_clk);
        for (int p = 0; p < NP; p++) begin
          d = 30'($urandom);
          vin_d[p] <= d;
          expq[p].push_back(expect_pix(p, x, y, d));
        end
        vin_v <= '1;
        vin_s <= {NP{x == 0 && y == 0}};
        vin_e <= {NP{x == w - 1}};
      end
    end
    @(posedge sys_clk);
    {vin_v, vin_s, vin_e} <= '0;
    repeat (8) @(posedge sys_clk);
    pw = w;
    ph = h;
    frames_sent++;
  endtask

  always @(posedge sys_clk) begin
    for (int p = 0; p < NP; p++)
      if (vout_v[p] === 1'b1) begin
        if (expq[p].size() == 0) begin
          mismatches++;
          $display("MISMATCH %0t pixel with no expectation", $time);
        end
        else check_pix(vout_d[p], expq[p].pop_front());
      end
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end

  initial begin
    logic [31:0] q;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {vin_d, vin_v, vin_s, vin_e, lost, rgen} = '0;
    {mismatches, cmp_count, frames_sent, pw, ph} = '0;
    rstn = 1'b0;
    void'($urandom(85));
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int p = 0; p < NP; p++) begin
      for (int i = 0; i < 8; i++) rd(4'(p * 8 + i), RST_TAB[i]);
      wr(4'(p * 8 + 6), 32'hffff_ffff);
      rd(4'(p * 8 + 6), 32'h0000_0000);
      wr(4'(p * 8 + 4), 32'hffff_ffff);
      rd(4'(p * 8 + 4), 32'h0000_0000);
    end
    wr(4'h1, 32'h0000_293f);
    rd(4'h1, 32'h0000_2828);
    wr(4'h2, 32'h0000_077f);
    rd(4'h2, 32'h0000_0764);
    bus(1'b1, 4'h1, 32'h0000_0505, 4'h1, q);
    rd(4'h1, 32'h0000_2805);
    rd(4'h9, 32'h0000_0a0a);
    cfg(0, 1, 0, 40, 40, 100, 2, 0, 0);
    cfg(1, 1, 0, 20, 30, 100, 1, 0, 0);
    frame(50, 10);
    frame(50, 10);
    // every colour, with both opacity end points and random ones between
    for (int c = 0; c < 8; c++) begin
      cfg(0, 1, 0, 40, 40, c == 0 ? 0 : c == 1 ? 100 : $urandom_range(100), c, 0, 0);
      cfg(1, 1, 0, 20, 30, 100, 7 - c, 0, 0);
      frame(50, 10);
    end
    for (int m = 0; m < 8; m++) begin
      cfg(0, 1, m / 4, 40, 40, 100, 1, 0, 0);
      cfg(1, m % 2, 0, 20, 30, 100, 2, 0, 0);
      @(posedge sys_clk);
      lost <= {1'b0, 1'(m / 2)};
      rgen <= {1'b0, 1'(m)};
      frame(50, 10);
    end
    lost <= '0;
    rgen <= '0;
    frame(30, 20);
    frame(30, 20);
    rd(4'h4, 32'h0014_001e);
    rd(4'hc, 32'h0014_001e);
    // zero opacity keeps pixels exact while the box moves
    cfg(0, 1, 0, 40, 40, 0, 0, 7, 1);
    cfg(1, 1, 0, 40, 40, 0, 0, 3, 0);
    repeat (3) frame(30, 20);
    bus(1'b0, 4'h5, 32'h0000_0000, 4'h0, q);
    check_reg(32'(q[12:0] === 13'd0 || q[12:0] === 13'd18), 32'h0000_0001);
    check_reg(32'(q[28:16] >= 1 && q[28:16] <= 3), 32'h0000_0001);
    bus(1'b0, 4'hd, 32'h0000_0000, 4'h0, q);
    check_reg(32'(q[1:0] === 2'b00 && q[12:0] >= 4 && q[12:0] <= 12), 32'h0000_0001);
    check_reg(32'(q[28:16] === 13'd0), 32'h0000_0001);
    for (int p = 0; p < NP; p++) begin
      check_reg(32'(fr[p]), 32'(frames_sent));
      check_reg(32'(ln[p]), 32'(18 * 10 + 5 * 20));
    end
    complete_run();
  end
endmodule
`default_nettype wire
